/* rtl/sdm_status_map.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - Auto mode finds video or transport alone
// - Manual mode passes non-conforming data through
// - Features enabled at reset, individually disableable
// - Each multi-function output picks one source
// - Line FIFO has four selectable modes
// - FIFO window 02Ch-42Bh, ancillary mode only
// - Loop lock and signal present feed lock
// - Received EDH flags: three groups of five
// - Error status: marker errors low, checksum above
// - Format bytes paired low/high in two registers
// - Four raster registers, 11/13/13/11 bits
// - Status registers ignore host writes
module sdm_status_map
   import sdm_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 rst_b,
   input  wire logic                 formatSelectAutomatic,
   input  wire logic                 pllLock,
   input  wire logic                 carrierDetect,
   input  wire logic                 smpteFound,
   input  wire logic                 asiFound,
   input  wire logic                 smpteBypassIn,
   output logic                      smpteBypassOut,
   output logic                      smpteBypassOe,
   input  wire logic                 asiSelIn,
   output logic                      asiSelOut,
   output logic                      asiSelOe,
   output logic                      locked,
   output logic                      dataThrough,
   output logic      [FEAT_W-1:0]    featureEn,
   output logic      [1:0]           fifoMode,
   input  wire logic                 hTiming,
   input  wire logic                 vTiming,
   input  wire logic                 fTiming,
   input  wire logic                 ancDetect,
   input  wire logic                 edhDetect,
   input  wire logic                 fifoLoad,
   output logic      [MFO_N-1:0]     mfo,
   input  wire logic [ERR_W-1:0]     errIn,
   input  wire logic [EDH_W-1:0]     edhInFlags,
   input  wire logic [EDH_W-1:0]     edhOutFlags,
   input  wire logic [FMT_W-1:0]     fmtInfo,
   input  wire logic [VFO_W-1:0]     vfoByte1,
   input  wire logic [VFO_W-1:0]     vfoByte2,
   input  wire logic [VFO_W-1:0]     vfoByte3,
   input  wire logic [VFO_W-1:0]     vfoByte4,
   input  wire logic [RS_NARROW-1:0] raster1,
   input  wire logic [RS_WIDE-1:0]   raster2,
   input  wire logic [RS_WIDE-1:0]   raster3,
   input  wire logic [RS_NARROW-1:0] raster4,
   input  wire logic                 fifoWrEn,
   input  wire logic [FIFO_AW-1:0]   fifoWrAddr,
   input  wire logic [WORD_W-1:0]    fifoWrData,
   input  wire logic                 sclk,
   input  wire logic                 csB,
   input  wire logic                 sdin,
   output logic                      sdout
);
   ////////////////////////////////////////////////////////////////////
   function automatic logic mfoPick(input logic [MSEL_W-1:0] sel,
                                    input logic [SRC_N-1:0]  src);
      logic r;
      r = 1'b0;
      case (sel)
         SRC_H:    r = src[0];
         SRC_V:    r = src[1];
         SRC_F:    r = src[2];
         SRC_ANC:  r = src[3];
         SRC_EDH:  r = src[4];
         SRC_LOAD: r = src[5];
         default:  r = 1'b0;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   sdm_lock_t               state_reg;
   sdm_lock_t               state_next;
   logic [FEAT_W-1:0]       feat_reg;
   logic [MFO_N*MSEL_W-1:0] msel_reg;
   logic [1:0]              fmode_reg;
   logic [ERR_W-1:0]        err_reg;
   logic [EDH_W-1:0]        edhIn_reg;
   logic [EDH_W-1:0]        edhOut_reg;
   logic [FMT_W-1:0]        fmt_reg;
   logic [DATA_W-1:0]       vfoA_reg;
   logic [DATA_W-1:0]       vfoB_reg;
   logic [RS_NARROW-1:0]    rs1_reg;
   logic [RS_WIDE-1:0]      rs2_reg;
   logic [RS_WIDE-1:0]      rs3_reg;
   logic [RS_NARROW-1:0]    rs4_reg;
   logic                    rdD1_reg;
   logic                    rdValid_reg;
   logic [DATA_W-1:0]       rdData_reg;
   logic                    rdStb;
   logic                    wrStb;
   logic [ADDR_W-1:0]       hAddr;
   logic [DATA_W-1:0]       hWrData;
   logic [WORD_W-1:0]       fifoRdData;
   logic [MFO_N-1:0]        mfo_next;

   ////////////////////////////////////////////////////////////////////
   // Lock and format selection
   // Auto mode owns the format pins; manual mode only reads them
   wire sigOk     = pllLock & carrierDetect;
   wire manAsi    = asiSelIn;
   wire manSmpte  = smpteBypassIn & ~asiSelIn;
   wire manThru   = ~smpteBypassIn & ~asiSelIn;
   wire autoFmtOk = smpteFound | asiFound;
   // Data-through has no sync word, so a good signal alone locks
   wire manFmtOk  = manAsi   ? asiFound :
                    manSmpte ? smpteFound : 1'b1;
   wire fmtOk     = formatSelectAutomatic ? autoFmtOk : manFmtOk;
   // Lock is taken from the next state so the pin is a clean flop
   wire goLock    = state_next == ST_LOCK;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_NOSIG: begin
            if (sigOk) begin
               state_next = ST_SEARCH;
            end
         end
         ST_SEARCH: begin
            if (!sigOk) begin
               state_next = ST_NOSIG;
            end else if (fmtOk) begin
               state_next = ST_LOCK;
            end
         end
         ST_LOCK: begin
            // Lost loop lock drops straight out, not via search
            if (!sigOk) begin
               state_next = ST_NOSIG;
            end else if (!fmtOk) begin
               state_next = ST_SEARCH;
            end
         end
         default: state_next = ST_NOSIG;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_reg      <= ST_NOSIG;
         locked         <= 1'b0;
         dataThrough    <= 1'b0;
         smpteBypassOut <= 1'b0;
         asiSelOut      <= 1'b0;
         smpteBypassOe  <= 1'b0;
         asiSelOe       <= 1'b0;
      end else begin
         state_reg   <= state_next;
         locked      <= goLock;
         dataThrough <= goLock & ~formatSelectAutomatic & manThru;
         // Smpte wins if both detectors fire in one cycle
         smpteBypassOut <= formatSelectAutomatic & goLock
                           & smpteFound;
         asiSelOut      <= formatSelectAutomatic & goLock
                           & asiFound & ~smpteFound;
         // The pins are outputs only in auto mode
         smpteBypassOe  <= formatSelectAutomatic;
         asiSelOe       <= formatSelectAutomatic;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Multi-function outputs
   wire [SRC_N-1:0] mfoSrc = {fifoLoad, edhDetect, ancDetect,
                              fTiming, vTiming, hTiming};

   genvar gi;
   generate
      for (gi = 0; gi < MFO_N; gi++) begin : g_mfo
         assign mfo_next[gi] = locked &
            mfoPick(msel_reg[gi*MSEL_W +: MSEL_W], mfoSrc);
      end
   endgenerate

   // Outputs are gated by the locked flop, so they fall one cycle after the other status pins
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mfo <= '0;
      end else begin
         mfo <= mfo_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Host port and control registers
   sdm_host_port u_port (
      .clock   (clock),
      .rst_b   (rst_b),
      .sclk    (sclk),
      .csB     (csB),
      .sdin    (sdin),
      .sdout   (sdout),
      .rdStb   (rdStb),
      .wrStb   (wrStb),
      .addr    (hAddr),
      .wrData  (hWrData),
      .rdValid (rdValid_reg),
      .rdData  (rdData_reg)
   );

   // Only the three control words decode a write strobe
   wire wrFeat  = wrStb & (hAddr == OFS_FEAT);
   wire wrMsel  = wrStb & (hAddr == OFS_MSEL);
   wire wrFmode = wrStb & (hAddr == OFS_FMODE);

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         feat_reg  <= FEAT_RST;
         msel_reg  <= MSEL_RST;
         fmode_reg <= FM_ALIGN;
      end else begin
         if (wrFeat) begin
            feat_reg <= hWrData[FEAT_W-1:0];
         end
         if (wrMsel) begin
            msel_reg <= hWrData[MFO_N*MSEL_W-1:0];
         end
         if (wrFmode) begin
            fmode_reg <= hWrData[1:0];
         end
      end
   end

   assign featureEn = feat_reg;
   assign fifoMode  = fmode_reg;

   ////////////////////////////////////////////////////////////////////
   // Status capture; a disabled feature reports nothing
   wire trsOn = feat_reg[FE_TRS];
   wire ancOn = feat_reg[FE_ANC];
   wire edhOn = feat_reg[FE_EDH];
   wire stdOn = feat_reg[FE_STD];

   // Error bits follow the checks that raise them
   wire [ERR_W-1:0] errMask = {{(ERR_W-3){edhOn}}, ancOn,
                               trsOn, trsOn};

   // Only hardware updates these; no host strobe reaches them
   // Snapshots, not sticky: a poll sees one cycle only
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         err_reg    <= '0;
         edhIn_reg  <= '0;
         edhOut_reg <= '0;
         fmt_reg    <= '0;
         vfoA_reg   <= '0;
         vfoB_reg   <= '0;
         rs1_reg    <= '0;
         rs2_reg    <= '0;
         rs3_reg    <= '0;
         rs4_reg    <= '0;
      end else begin
         err_reg    <= locked ? (errIn & errMask) : '0;
         edhIn_reg  <= edhOn ? edhInFlags : '0;
         edhOut_reg <= edhOn ? edhOutFlags : '0;
         fmt_reg    <= stdOn ? fmtInfo : '0;
         vfoA_reg   <= stdOn ? {vfoByte2, vfoByte1} : '0;
         vfoB_reg   <= stdOn ? {vfoByte4, vfoByte3} : '0;
         rs1_reg    <= stdOn ? raster1 : '0;
         rs2_reg    <= stdOn ? raster2 : '0;
         rs3_reg    <= stdOn ? raster3 : '0;
         rs4_reg    <= stdOn ? raster4 : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Line FIFO window
   // Outside ancillary mode the window reads zero
   wire               inWin   = (hAddr >= FIFO_LO) && (hAddr <= FIFO_HI);
   wire               fifoOk  = inWin && (fmode_reg == FM_ANCX);
   wire [ADDR_W-1:0]  winOfs  = hAddr - FIFO_LO;
   wire [FIFO_AW-1:0] fifoRdA = winOfs[FIFO_AW-1:0];

   // Only the neighbour writes the line; the host just reads it
   sdm_line_fifo u_fifo (
      .clock  (clock),
      .wrEn   (fifoWrEn),
      .wrAddr (fifoWrAddr),
      .wrData (fifoWrData),
      .rdAddr (fifoRdA),
      .rdData (fifoRdData)
   );

   ////////////////////////////////////////////////////////////////////
   // Read mux; unused bits and unmapped words read zero
   wire [DATA_W-1:0] rdErr  = {{(DATA_W-ERR_W){1'b0}}, err_reg};
   wire [DATA_W-1:0] rdEdhI = {1'b0, edhIn_reg};
   wire [DATA_W-1:0] rdEdhO = {1'b0, edhOut_reg};
   wire [DATA_W-1:0] rdFmt  = {{(DATA_W-FMT_W){1'b0}}, fmt_reg};
   wire [DATA_W-1:0] rdRs1  = {{(DATA_W-RS_NARROW){1'b0}}, rs1_reg};
   wire [DATA_W-1:0] rdRs2  = {{(DATA_W-RS_WIDE){1'b0}}, rs2_reg};
   wire [DATA_W-1:0] rdRs3  = {{(DATA_W-RS_WIDE){1'b0}}, rs3_reg};
   wire [DATA_W-1:0] rdRs4  = {{(DATA_W-RS_NARROW){1'b0}}, rs4_reg};
   wire [DATA_W-1:0] rdFeat = {{(DATA_W-FEAT_W){1'b0}}, feat_reg};
   wire [DATA_W-1:0] rdMsel = {{(DATA_W-MFO_N*MSEL_W){1'b0}}, msel_reg};
   wire [DATA_W-1:0] rdFm   = {{(DATA_W-2){1'b0}}, fmode_reg};
   wire [DATA_W-1:0] rdFifo = {{(DATA_W-WORD_W){1'b0}}, fifoRdData};

   // Offsets are disjoint, so the chain order is free
   wire [DATA_W-1:0] rdMux =
      (hAddr == OFS_ERR)   ? rdErr  :
      (hAddr == OFS_EDHI)  ? rdEdhI :
      (hAddr == OFS_EDHO)  ? rdEdhO :
      (hAddr == OFS_FMT)   ? rdFmt  :
      (hAddr == OFS_VFOA)  ? vfoA_reg :
      (hAddr == OFS_VFOB)  ? vfoB_reg :
      (hAddr == OFS_RS1)   ? rdRs1  :
      (hAddr == OFS_RS2)   ? rdRs2  :
      (hAddr == OFS_RS3)   ? rdRs3  :
      (hAddr == OFS_RS4)   ? rdRs4  :
      (hAddr == OFS_FEAT)  ? rdFeat :
      (hAddr == OFS_MSEL)  ? rdMsel :
      (hAddr == OFS_FMODE) ? rdFm   :
      fifoOk               ? rdFifo : '0;

   // Two-cycle read: RAM output is valid one edge after the strobe
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rdD1_reg    <= 1'b0;
         rdValid_reg <= 1'b0;
         rdData_reg  <= '0;
      end else begin
         rdD1_reg    <= rdStb;
         rdValid_reg <= rdD1_reg;
         if (rdD1_reg) begin
            rdData_reg <= rdMux;
         end
      end
   end
endmodule

/* rtl/sdm_pkg.sv */
package sdm_pkg;
   localparam int ADDR_W    = 12;
   localparam int DATA_W    = 16;
   localparam int WORD_W    = 10;
   localparam int FIFO_AW   = 10;
   localparam int FIFO_DEP  = 1024;
   localparam int CNT_W     = 6;
   localparam int ERR_W     = 7;
   localparam int EDH_W     = 15;
   localparam int FMT_W     = 11;
   localparam int VFO_W     = 8;
   localparam int RS_NARROW = 11;
   localparam int RS_WIDE   = 13;
   localparam int FEAT_W    = 5;
   localparam int MFO_N     = 3;
   localparam int MSEL_W    = 3;
   localparam int SRC_N     = 6;

   // Host frame: command word, then data word, MSB first
   localparam logic [CNT_W-1:0] CMD_LAST   = 6'h0f;
   localparam logic [CNT_W-1:0] FRAME_LAST = 6'h1f;
   localparam int               CMD_RD_BIT = 15;

   localparam logic [ADDR_W-1:0] OFS_ERR   = 12'h001;
   localparam logic [ADDR_W-1:0] OFS_EDHI  = 12'h002;
   localparam logic [ADDR_W-1:0] OFS_EDHO  = 12'h003;
   localparam logic [ADDR_W-1:0] OFS_FMT   = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_VFOA  = 12'h00f;
   localparam logic [ADDR_W-1:0] OFS_VFOB  = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_RS1   = 12'h011;
   localparam logic [ADDR_W-1:0] OFS_RS2   = 12'h012;
   localparam logic [ADDR_W-1:0] OFS_RS3   = 12'h013;
   localparam logic [ADDR_W-1:0] OFS_RS4   = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_FEAT  = 12'h020;
   localparam logic [ADDR_W-1:0] OFS_MSEL  = 12'h021;
   localparam logic [ADDR_W-1:0] OFS_FMODE = 12'h022;
   localparam logic [ADDR_W-1:0] FIFO_LO   = 12'h02c;
   localparam logic [ADDR_W-1:0] FIFO_HI   = 12'h42b;

   // Feature enable bits
   localparam int FE_TRS   = 0;
   localparam int FE_ANC   = 1;
   localparam int FE_EDH   = 2;
   localparam int FE_STD   = 3;
   localparam logic [FEAT_W-1:0] FEAT_RST = 5'h1f;
   localparam logic [MFO_N*MSEL_W-1:0] MSEL_RST = 9'h088;

   localparam logic [MSEL_W-1:0] SRC_H    = 3'h0;
   localparam logic [MSEL_W-1:0] SRC_V    = 3'h1;
   localparam logic [MSEL_W-1:0] SRC_F    = 3'h2;
   localparam logic [MSEL_W-1:0] SRC_ANC  = 3'h3;
   localparam logic [MSEL_W-1:0] SRC_EDH  = 3'h4;
   localparam logic [MSEL_W-1:0] SRC_LOAD = 3'h5;

   localparam logic [1:0] FM_ALIGN = 2'h0;
   localparam logic [1:0] FM_ANCX  = 2'h3;

   typedef enum logic [2:0] {
      ST_NOSIG  = 3'b001,
      ST_SEARCH = 3'b010,
      ST_LOCK   = 3'b100
   } sdm_lock_t;
endpackage

/* rtl/sdm_line_fifo.sv */
`timescale 1ns/1ns
module sdm_line_fifo
   import sdm_pkg::*;
(
   input  wire logic               clock,
   input  wire logic               wrEn,
   input  wire logic [FIFO_AW-1:0] wrAddr,
   input  wire logic [WORD_W-1:0]  wrData,
   input  wire logic [FIFO_AW-1:0] rdAddr,
   output logic      [WORD_W-1:0]  rdData
);
   logic [WORD_W-1:0] mem [FIFO_DEP];

   // Registered read keeps the array mappable to block RAM
   always_ff @(posedge clock) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule

/* rtl/sdm_host_port.sv */
`timescale 1ns/1ns
module sdm_host_port
   import sdm_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic              sclk,
   input  wire logic              csB,
   input  wire logic              sdin,
   output logic                   sdout,
   output logic                   rdStb,
   output logic                   wrStb,
   output logic      [ADDR_W-1:0] addr,
   output logic      [DATA_W-1:0] wrData,
   input  wire logic              rdValid,
   input  wire logic [DATA_W-1:0] rdData
);
   logic              sclkPrev_reg;
   logic [CNT_W-1:0]  bitCnt_reg;
   logic [DATA_W-1:0] shift_reg;
   logic [DATA_W-1:0] cmd_reg;
   logic [DATA_W-1:0] out_reg;

   wire              rise    = sclk & ~sclkPrev_reg & ~csB;
   wire              fall    = ~sclk & sclkPrev_reg & ~csB;
   wire [DATA_W-1:0] shifted = {shift_reg[DATA_W-2:0], sdin};
   wire              cmdDone = rise & (bitCnt_reg == CMD_LAST);
   wire              frmDone = rise & (bitCnt_reg == FRAME_LAST);
   wire              isRead  = cmd_reg[CMD_RD_BIT];
   wire              dataPh  = bitCnt_reg > CMD_LAST;

   assign addr = cmd_reg[ADDR_W-1:0];

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sclkPrev_reg <= 1'b0;
         bitCnt_reg   <= '0;
         shift_reg    <= '0;
         cmd_reg      <= '0;
         out_reg      <= '0;
         sdout        <= 1'b0;
         rdStb        <= 1'b0;
         wrStb        <= 1'b0;
         wrData       <= '0;
      end else begin
         sclkPrev_reg <= sclk;
         rdStb        <= cmdDone & shifted[CMD_RD_BIT];
         wrStb        <= frmDone & ~isRead;
         if (csB) begin
            bitCnt_reg <= '0;
         end else if (rise) begin
            bitCnt_reg <= bitCnt_reg + 1'b1;
            shift_reg  <= shifted;
         end
         if (cmdDone) begin
            cmd_reg <= shifted;
         end
         if (frmDone) begin
            wrData <= shifted;
         end
         // Read data leaves on falling edges, MSB first
         if (rdValid) begin
            out_reg <= rdData;
         end else if (fall & dataPh & isRead) begin
            sdout   <= out_reg[DATA_W-1];
            out_reg <= {out_reg[DATA_W-2:0], 1'b0};
         end
      end
   end
endmodule

/* bench/sdm_status_map_monitor.sv */
`timescale 1ns/1ns
module sdm_status_map_monitor
   import sdm_pkg::*;
(
   input wire logic              clock,
   input wire logic              rst_b,
   input wire logic              formatSelectAutomatic,
   input wire logic              pllLock,
   input wire logic              carrierDetect,
   input wire logic              smpteBypassIn,
   input wire logic              asiSelIn,
   input wire logic              smpteBypassOut,
   input wire logic              smpteBypassOe,
   input wire logic              asiSelOut,
   input wire logic              asiSelOe,
   input wire logic              locked,
   input wire logic              dataThrough,
   input wire logic [FEAT_W-1:0] featureEn,
   input wire logic [1:0]        fifoMode,
   input wire logic [MFO_N-1:0]  mfo,
   input wire logic              csB
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////
   smpte_oe_a: assert property ($past(rst_b) |->
      smpteBypassOe == $past(formatSelectAutomatic))
      else $error("bypass pin enable not following mode");
   asi_oe_a: assert property ($past(rst_b) |->
      asiSelOe == $past(formatSelectAutomatic))
      else $error("transport pin enable not following mode");
   status_excl_a: assert property (smpteBypassOe |->
      !(smpteBypassOut && asiSelOut))
      else $error("both format status pins high");
   through_manual_a: assert property (dataThrough |->
      !$past(formatSelectAutomatic) && !$past(smpteBypassIn)
      && !$past(asiSelIn)) else $error("data-through outside manual");
   lock_needs_sig_a: assert property ($rose(locked) |->
      $past(pllLock) && $past(carrierDetect))
      else $error("lock without loop lock and signal");
   lock_drop_a: assert property (!pllLock [*3] |-> !locked)
      else $error("lock held after loop lost");
   mfo_quiet_a: assert property (|mfo |-> locked || $past(locked))
      else $error("multi-function output active while unlocked");
   reset_feat_a: assert property ($past(!rst_b) |->
      featureEn == FEAT_RST && fifoMode == FM_ALIGN)
      else $error("feature or fifo mode wrong after reset");
   cfg_quiet_a: assert property (csB [*6] |->
      $stable(featureEn) && $stable(fifoMode))
      else $error("settings changed without host frame");
endmodule
bind sdm_status_map sdm_status_map_monitor mon (.clock, .rst_b,
   .formatSelectAutomatic, .pllLock, .carrierDetect, .smpteBypassIn,
   .asiSelIn, .smpteBypassOut, .smpteBypassOe, .asiSelOut, .asiSelOe,
   .locked, .dataThrough, .featureEn, .fifoMode, .mfo, .csB);

/* bench/sdm_signal_source.sv */
`timescale 1ns/1ns
module sdm_signal_source (
   input  wire logic       clock,
   input  wire logic       present,
   input  wire logic [1:0] kind,
   input  wire logic [7:0] delay,
   output logic            pllLock,
   output logic            carrierDetect,
   output logic            smpteFound,
   output logic            asiFound
);
   logic [7:0] holdCnt_reg;
   // Loop takes a while to settle; delay lets the bench be prompt or slow
   always_ff @(posedge clock) begin
      if (!present)
         holdCnt_reg <= 8'h00;
      else if (holdCnt_reg != 8'hff)
         holdCnt_reg <= holdCnt_reg + 8'h01;
   end
   assign carrierDetect = present;
   assign pllLock = present && holdCnt_reg >= delay;
   // Kind 3 is a stream of neither format, so no sync word is ever seen
   assign smpteFound = pllLock && kind == 2'h1;
   assign asiFound = pllLock && kind == 2'h2;
endmodule

/* bench/tb_sdm_status_map.sv */
`timescale 1ns/1ns
module tb_sdm_status_map;
   import sdm_pkg::*;
   logic        clock, rst_b, formatSelectAutomatic, pllLock, carrierDetect;
   logic        smpteFound, asiFound, smpteBypassIn, smpteBypassOut;
   logic        smpteBypassOe, asiSelIn, asiSelOut, asiSelOe, locked;
   logic        dataThrough, hTiming, vTiming, fTiming, ancDetect;
   logic        edhDetect, fifoLoad, fifoWrEn, sclk, csB, sdin, sdout;
   logic        smpteDrv, asiDrv, present;
   logic [1:0]  fifoMode, kind;
   logic [2:0]  mfo;
   logic [4:0]  featureEn, feat;
   logic [6:0]  errIn;
   logic [7:0]  vfoByte1, vfoByte2, vfoByte3, vfoByte4, delay;
   logic [9:0]  fifoWrAddr, fifoWrData, d0, d1;
   logic [10:0] fmtInfo, raster1, raster4;
   logic [12:0] raster2, raster3;
   logic [14:0] edhInFlags, edhOutFlags;
   logic [5:0]  sv;
   int          nErrors, checksDone, seed;
   // Resolved level of the shared pins: device drives in auto mode
   assign smpteBypassIn = smpteBypassOe ? smpteBypassOut : smpteDrv;
   assign asiSelIn = asiSelOe ? asiSelOut : asiDrv;
   assign sv = {fifoLoad, edhDetect, ancDetect, fTiming, vTiming, hTiming};
   sdm_signal_source src (.clock, .present, .kind, .delay, .pllLock,
      .carrierDetect, .smpteFound, .asiFound);
   sdm_status_map dut (.clock, .rst_b, .formatSelectAutomatic, .pllLock,
      .carrierDetect, .smpteFound, .asiFound, .smpteBypassIn,
      .smpteBypassOut, .smpteBypassOe, .asiSelIn, .asiSelOut, .asiSelOe,
      .locked, .dataThrough, .featureEn, .fifoMode, .hTiming, .vTiming,
      .fTiming, .ancDetect, .edhDetect, .fifoLoad, .mfo, .errIn,
      .edhInFlags, .edhOutFlags, .fmtInfo, .vfoByte1, .vfoByte2,
      .vfoByte3, .vfoByte4, .raster1, .raster2, .raster3, .raster4,
      .fifoWrEn, .fifoWrAddr, .fifoWrData, .sclk, .csB, .sdin, .sdout);
   ////////////////////////////////////////
   initial begin
      clock = 1'h0;
      forever #20 clock = ~clock;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask
   task automatic endOfTest;
      $display("checks %0d mismatches %0d", checksDone, nErrors);
      if (nErrors == 0 && checksDone > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checksDone++;
      if (got !== exp) begin
         nErrors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // One frame: command then data; half periods of 4 give the port slack
   task automatic host(input logic rd, input logic [11:0] a,
                       input logic [15:0] wd, output logic [15:0] rdv);
      logic [31:0] fr;
      fr = {rd, 3'h0, a, wd};
      rdv = 16'h0000;
      csB = 1'h0;
      for (int i = 0; i < 32; i++) begin
         sclk = 1'h0;
         sdin = fr[31-i];
         cyc(4);
         if (i >= 16)
            rdv[31-i] = sdout;
         sclk = 1'h1;
         cyc(4);
      end
      sclk = 1'h0;
      cyc(4);
      csB = 1'h1;
      cyc(2);
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      logic [15:0] x;
      host(1'h0, a, d, x);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [15:0] e);
      logic [15:0] x;
      host(1'h1, a, 16'h0000, x);
      chk(x, e);
   endtask
   task automatic rnd;
      {errIn, edhInFlags, edhOutFlags, fmtInfo} =
         48'({$random(seed), $random(seed)});
      {vfoByte1, vfoByte2, vfoByte3, vfoByte4} = $random(seed);
      {raster1, raster2, raster3, raster4} =
         48'({$random(seed), $random(seed)});
      {fifoLoad, edhDetect, ancDetect, fTiming, vTiming, hTiming} =
         6'($random(seed));
   endtask
   function automatic logic [15:0] exp_reg(input logic [11:0] a,
                                           input logic [4:0] f);
      logic [15:0] s;
      s = {16{f[3]}};
      case (a)
         OFS_ERR:  return 16'(errIn & {{4{f[2]}}, f[1], {2{f[0]}}});
         OFS_EDHI: return {1'h0, edhInFlags & {15{f[2]}}};
         OFS_EDHO: return {1'h0, edhOutFlags & {15{f[2]}}};
         OFS_FMT:  return 16'(fmtInfo) & s;
         OFS_VFOA: return {vfoByte2, vfoByte1} & s;
         OFS_VFOB: return {vfoByte4, vfoByte3} & s;
         OFS_RS1:  return 16'(raster1) & s;
         OFS_RS2:  return 16'(raster2) & s;
         OFS_RS3:  return 16'(raster3) & s;
         OFS_RS4:  return 16'(raster4) & s;
         default:  return 16'h0000;
      endcase
   endfunction
   task automatic mode(input logic au, sb, as, input logic [1:0] k,
                       input logic el, dt);
      int n;
      present = 1'h0;
      cyc(4);
      formatSelectAutomatic = au;
      smpteDrv = sb;
      asiDrv = as;
      kind = k;
      delay = {3'h0, 5'($random(seed))};
      present = 1'h1;
      for (n = 0; n < 80 && !(el && locked === 1'h1); n++)
         cyc(1);
      if (el && n == 80) begin
         nErrors++;
         $display("mismatch at %0t: lock never came", $time);
         endOfTest();
      end
      cyc(2);
      chk(16'({locked, dataThrough, smpteBypassOe, asiSelOe,
               au & smpteBypassOut, au & asiSelOut}),
          16'({el, dt, au, au, au & el & (k == 2'h1),
               au & el & (k == 2'h2)}));
      $display("mode test done");
   endtask
   ////////////////////////////////////////
   initial begin
      seed = 32'hec27;
      {rst_b, formatSelectAutomatic, smpteDrv, asiDrv, present} = 5'h00;
      {kind, delay, fifoWrEn, fifoWrAddr, fifoWrData} = 31'h0;
      {sclk, sdin, csB} = 3'h1;
      rnd();
      cyc(6);
      rst_b = 1'h1;
      chk(16'(featureEn), 16'h001f);
      rdchk(OFS_FEAT, 16'h001f);
      rdchk(OFS_MSEL, 16'h0088);
      mode(1'h1, 1'h0, 1'h0, 2'h3, 1'h0, 1'h0);
      mode(1'h1, 1'h0, 1'h0, 2'h2, 1'h1, 1'h0);
      mode(1'h0, 1'h1, 1'h0, 2'h1, 1'h1, 1'h0);
      mode(1'h0, 1'h1, 1'h1, 2'h2, 1'h1, 1'h0);
      mode(1'h0, 1'h1, 1'h0, 2'h2, 1'h0, 1'h0);
      mode(1'h0, 1'h0, 1'h0, 2'h3, 1'h1, 1'h1);
      mode(1'h1, 1'h0, 1'h0, 2'h1, 1'h1, 1'h0);
      for (int r = 0; r < 4; r++) begin
         rnd();
         feat = (r == 0) ? 5'h1f : 5'($random(seed));
         wr(OFS_FEAT, 16'(feat));
         chk(16'(featureEn), 16'(feat));
         wr(12'(OFS_ERR + r * 5), 16'hffff);
         for (int a = 0; a < 'h16; a++)
            rdchk(12'(a), exp_reg(12'(a), feat));
         $display("status round done");
      end
      wr(OFS_FEAT, 16'h001f);
      for (int s = 0; s < 8; s++) begin
         wr(OFS_MSEL, 16'({3{3'(s)}}));
         rnd();
         cyc(3);
         chk(16'(mfo), 16'({3{s < 6 && sv[s % 6]}}));
      end
      $display("output select test done");
      {d0, d1} = 20'($random(seed));
      fifoWrEn = 1'h1;
      fifoWrData = d0;
      cyc(1);
      fifoWrAddr = 10'h3ff;
      fifoWrData = d1;
      cyc(1);
      fifoWrEn = 1'h0;
      for (int m = 0; m < 4; m++) begin
         wr(OFS_FMODE, 16'(m));
         chk(16'(fifoMode), 16'(m));
         rdchk(FIFO_LO, (m == 3) ? 16'(d0) : 16'h0000);
      end
      rdchk(FIFO_HI, 16'(d1));
      rdchk(FIFO_HI + 12'h001, 16'h0000);
      $display("fifo window test done");
      endOfTest();
   end
endmodule
